// ==== design/expansion_bus_regs.svh ====
`ifndef EXPANSION_BUS_REGS_SVH
`define EXPANSION_BUS_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define EB_CFG_OFF      8'h00
`define EB_ADDR_OFF     8'h04
`define EB_CTRL_OFF     8'h08
`define EB_WDATA_OFF    8'h0c
`define EB_STATUS_OFF   8'h10
`define EB_RDATA_OFF    8'h14

// ----------------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------------
`define EB_CFG_PROTO    0
`define EB_CFG_MUX      1
`define EB_CFG_AEXT_LO  2
`define EB_CFG_AEXT_HI  3
`define EB_CFG_DEXT_LO  4
`define EB_CFG_DEXT_HI  6
`define EB_CFG_BEXT_LO  7
`define EB_CFG_BEXT_HI  9
`define EB_CFG_MASK     32'h0000_03ff
`define EB_CFG_RESET    32'h0000_0000

// ----------------------------------------------------------------------
// Address, command and status fields
// ----------------------------------------------------------------------
`define EB_ADDR_MASK    32'h0003_ffff
`define EB_ADDR_HI      17
`define EB_CTRL_GO      0
`define EB_CTRL_READ    1
`define EB_CTRL_BE_LO   4
`define EB_CTRL_BE_HI   7
`define EB_STAT_BUSY    0
`define EB_STAT_DONE    1

// ----------------------------------------------------------------------
// Bus answers and counter widths
// ----------------------------------------------------------------------
`define EB_RESP_OK      2'h0
`define EB_RESP_ERR     2'h2
`define EB_CNT_W        3

`endif

// ==== design/expansion_bus_pkg.sv ====
package expansion_bus_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_ACK,
    ST_ADDR,
    ST_DATA,
    ST_POST,
    ST_REL,
    ST_GAP
  } bus_state_type;

  typedef enum logic {
    PROTO_SEPARATE,
    PROTO_ADDR_STROBE
  } proto_type;

endpackage

// ==== design/sync2.sv ====
`timescale 1ns/1ps

module sync2 #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] init,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_type;

  sync_state_type st_q;
  sync_state_type st_d;

  initial begin
    if (W < 1) begin
      $error("sync2 width must be at least one");
    end
  end

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // Reset value is a constant pattern per bit, idle level of each pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2 ^ init;

endmodule

// ==== design/expansion_bus_master.sv ====
`timescale 1ns/1ps
`include "expansion_bus_regs.svh"

// Notes on behaviour
// a configuration bit picks separate strobes or address/data strobe signalling.
// separate strobes: latch enable low while address valid, whole cycle.
// separate strobes: read strobe pulses low on reads, high on writes.
// separate strobes: write strobe pulses low on writes, high on reads.
// separate strobes: active-high request raised when the bus is needed.
// arbiter raises grant, holds it until request falls, then drops it.
// with no arbiter, active-high grant is tied asserted.
// address strobe low while address valid, for the whole cycle.
// data strobe pulses for reads and writes; direction line gives meaning.
// address strobe style: active-low request driven low when bus needed.
// arbiter drives grant low and holds it until request released.
// with no arbiter, active-low grant is tied low.
// granted, wait acknowledge free, drive it low, release after cycle.
// idle lines float; request raised, then grant sampled.
// nothing driven before the grant is seen.
// separate strobes: request dropped after access, then lines float.
// address strobe style: request low, wait grant before driving lines.
// address strobe style: request released shortly after cycle begins.
// address strobe style: acknowledge released first, then lines float.
// non-multiplexed: each byte enable selects one byte-wide peripheral.
// multiplexed: one 8-bit lane per transfer, no four-byte transfers.
// address held one bus period plus zero to three extra.
// data held one bus period plus zero to seven extra.
// wait one bus period plus zero to seven before re-requesting.
// unselected protocol strobes stay inactive; no driving without grant.
module expansion_bus_master #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              local_bus_clock,
  input  wire logic [31:0]       local_addr_data_i,
  output logic [31:0]            local_addr_data_o,
  output logic                   local_addr_data_oe_n,
  output logic [3:0]             local_byte_enable_n,
  output logic                   ctrl_oe_n,
  output logic                   address_latch_n,
  output logic                   read_strobe_n,
  output logic                   write_strobe_n,
  output logic                   bus_request_hi,
  input  wire logic              bus_grant_hi,
  output logic                   address_strobe_n,
  output logic                   data_strobe_n,
  output logic                   read_not_write,
  output logic                   bus_request_n,
  input  wire logic              bus_grant_n,
  input  wire logic              grant_acknowledge_n_i,
  output logic                   grant_acknowledge_n_o,
  output logic                   grant_acknowledge_n_oe_n
);
  import expansion_bus_pkg::*;

  typedef struct packed {
    bus_state_type         state;
    logic [`EB_CNT_W-1:0]  cnt;
    logic                  clk_prev;
    logic [31:0]           cfg;
    logic [31:0]           addr;
    logic [31:0]           wdat;
    logic                  rd;
    logic [3:0]            be;
    logic [31:0]           rdat;
    logic                  done;
    logic                  aw_got;
    logic                  w_got;
    logic [7:0]            waddr;
    logic [31:0]           wbuf;
    logic [3:0]            wmask;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    logic [31:0]           ad_o;
    logic                  ad_oe_n;
    logic                  ctrl_oe_n;
    logic                  ale_n;
    logic                  rd_n;
    logic                  wr_n;
    logic                  hold;
    logic                  as_n;
    logic                  ds_n;
    logic                  rnw;
    logic                  br_n;
    logic                  ack_oe_n;
  } master_state_type;

  master_state_type q;
  master_state_type d;

  logic [35:0] sync_out;
  logic        s_clk;
  logic        s_grant_hi;
  logic        s_grant_n;
  logic        s_ack_n;
  logic [31:0] s_ad;
  logic        tick;
  logic        granted;
  logic        sep;
  logic [3:0]  be_raw;
  logic [3:0]  be_low;
  logic [31:0] lane_mask;

  initial begin
    if (ADDR_W < 5 || ADDR_W > 32) begin
      $error("expansion_bus_master address width must lie between 5 and 32");
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Active-low inputs are inverted around the flops so reset reads idle
  sync2 #(.W(36)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({local_bus_clock, bus_grant_hi, bus_grant_n, grant_acknowledge_n_i,
                local_addr_data_i} ^ 36'h3_0000_0000),
    .init    (36'h3_0000_0000),
    .q       (sync_out)
  );

  assign s_clk      = sync_out[35];
  assign s_grant_hi = sync_out[34];
  assign s_grant_n  = sync_out[33];
  assign s_ack_n    = sync_out[32];
  assign s_ad       = sync_out[31:0];
  assign tick       = s_clk & ~q.clk_prev;
  assign sep        = (q.cfg[`EB_CFG_PROTO] == PROTO_SEPARATE);
  assign granted    = sep ? s_grant_hi : ~s_grant_n;
  assign be_raw     = q.wbuf[`EB_CTRL_BE_HI:`EB_CTRL_BE_LO];
  assign be_low     = be_raw & 4'(~be_raw + 4'h1);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_mask[i*8 +: 8] = {8{q.be[i]}};
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d          = q;
    d.clk_prev = s_clk;

    // Register slave: address and data taken in either order
    if (awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.waddr  = 8'(awaddr);
    end
    if (wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wbuf  = wdata;
      d.wmask = wstrb;
    end
    if (bready && q.bvalid) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = `EB_RESP_OK;
      case (q.waddr)
        `EB_CFG_OFF: begin
          // Frozen while a bus cycle runs so the protocol cannot switch mid-way
          if (q.state == ST_IDLE) begin
            d.cfg = merge(q.cfg, q.wbuf, q.wmask) & `EB_CFG_MASK;
          end
        end
        `EB_ADDR_OFF: begin
          d.addr = merge(q.addr, q.wbuf, q.wmask) & `EB_ADDR_MASK;
        end
        `EB_WDATA_OFF: begin
          d.wdat = merge(q.wdat, q.wbuf, q.wmask);
        end
        `EB_CTRL_OFF: begin
          // Start is ignored while busy; software polls the busy bit
          if (q.wmask[0] && q.wbuf[`EB_CTRL_GO] && q.state == ST_IDLE) begin
            d.rd    = q.wbuf[`EB_CTRL_READ];
            d.be    = q.cfg[`EB_CFG_MUX] ? be_low : be_raw;
            d.done  = 1'b0;
            d.state = ST_REQ;
            d.hold  = sep;
            d.br_n  = sep;
          end
        end
        `EB_STATUS_OFF, `EB_RDATA_OFF: begin
        end
        default: begin
          d.bresp = `EB_RESP_ERR;
        end
      endcase
    end
    if (rready && q.rvalid) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = `EB_RESP_OK;
      case (8'(araddr))
        `EB_CFG_OFF:    d.rdata = q.cfg;
        `EB_ADDR_OFF:   d.rdata = q.addr;
        `EB_CTRL_OFF:   d.rdata = {24'h00_0000, q.be, 2'h0, q.rd, 1'b0};
        `EB_WDATA_OFF:  d.rdata = q.wdat;
        `EB_STATUS_OFF: d.rdata = {30'h0000_0000, q.done, q.state != ST_IDLE};
        `EB_RDATA_OFF:  d.rdata = q.rdat;
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = `EB_RESP_ERR;
        end
      endcase
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;

    // Expansion bus sequencer, paced by edges of the bus clock
    case (q.state)
      ST_IDLE: begin
      end
      ST_REQ: begin
        if (granted && (tick || !sep)) begin
          d.state = sep ? ST_ADDR : ST_ACK;
        end
      end
      ST_ACK: begin
        if (s_ack_n && tick) begin
          d.ack_oe_n = 1'b0;
          d.state    = ST_ADDR;
        end
      end
      default: begin
      end
    endcase
    if (q.state != d.state && d.state == ST_ADDR) begin
      d.ad_o      = q.addr;
      d.ad_oe_n   = 1'b0;
      d.ctrl_oe_n = 1'b0;
      d.ale_n     = !sep;
      d.as_n      = sep;
      d.rnw       = q.rd;
      d.cnt       = `EB_CNT_W'(q.cfg[`EB_CFG_AEXT_HI:`EB_CFG_AEXT_LO]);
    end
    if (tick) begin
      case (q.state)
        ST_ADDR: begin
          if (q.cnt == '0) begin
            d.state   = ST_DATA;
            d.ad_o    = q.wdat;
            d.ad_oe_n = q.rd;
            d.rd_n    = !(sep && q.rd);
            d.wr_n    = !(sep && !q.rd);
            d.ds_n    = sep;
            d.br_n    = 1'b1;
            d.cnt     = q.cfg[`EB_CFG_DEXT_HI:`EB_CFG_DEXT_LO];
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        ST_DATA: begin
          if (q.cnt == '0) begin
            d.state = ST_POST;
            d.rd_n  = 1'b1;
            d.wr_n  = 1'b1;
            d.ds_n  = 1'b1;
            if (q.rd) begin
              d.rdat = s_ad & lane_mask;
            end
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        ST_POST: begin
          d.state    = ST_REL;
          d.hold     = 1'b0;
          d.ale_n    = 1'b1;
          d.as_n     = 1'b1;
          d.ack_oe_n = 1'b1;
        end
        ST_REL: begin
          d.state     = ST_GAP;
          d.ad_oe_n   = 1'b1;
          d.ctrl_oe_n = 1'b1;
          d.done      = 1'b1;
          d.cnt       = q.cfg[`EB_CFG_BEXT_HI:`EB_CFG_BEXT_LO];
        end
        ST_GAP: begin
          if (q.cnt == '0) begin
            d.state = ST_IDLE;
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q           <= '0;
      q.state     <= ST_IDLE;
      q.cfg       <= `EB_CFG_RESET;
      q.awready   <= 1'b1;
      q.wready    <= 1'b1;
      q.arready   <= 1'b1;
      q.ad_oe_n   <= 1'b1;
      q.ctrl_oe_n <= 1'b1;
      q.ale_n     <= 1'b1;
      q.rd_n      <= 1'b1;
      q.wr_n      <= 1'b1;
      q.as_n      <= 1'b1;
      q.ds_n      <= 1'b1;
      q.rnw       <= 1'b1;
      q.br_n      <= 1'b1;
      q.ack_oe_n  <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign awready                  = q.awready;
  assign wready                   = q.wready;
  assign bvalid                   = q.bvalid;
  assign bresp                    = q.bresp;
  assign arready                  = q.arready;
  assign rvalid                   = q.rvalid;
  assign rresp                    = q.rresp;
  assign rdata                    = q.rdata;
  assign local_addr_data_o        = q.ad_o;
  assign local_addr_data_oe_n     = q.ad_oe_n;
  assign local_byte_enable_n      = ~q.be;
  assign ctrl_oe_n                = q.ctrl_oe_n;
  assign address_latch_n          = q.ale_n;
  assign read_strobe_n            = q.rd_n;
  assign write_strobe_n           = q.wr_n;
  assign bus_request_hi           = q.hold;
  assign address_strobe_n         = q.as_n;
  assign data_strobe_n            = q.ds_n;
  assign read_not_write           = q.rnw;
  assign bus_request_n            = q.br_n;
  assign grant_acknowledge_n_o    = 1'b0;
  assign grant_acknowledge_n_oe_n = q.ack_oe_n;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [3:0] addr_ticks;
  always_ff @(posedge aclk) begin
    if (!aresetn || q.state != ST_ADDR) begin
      addr_ticks <= 4'h0;
    end else if (ce && tick) begin
      addr_ticks <= addr_ticks + 4'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_unused_strobes;
    sep |-> address_strobe_n && data_strobe_n && bus_request_n;
  endproperty
  a_unused_strobes: assert property (p_unused_strobes) else $error("idle strobes driven");

  property p_drive_after_grant;
    $fell(ctrl_oe_n) |-> $past(granted);
  endproperty
  a_drive_after_grant: assert property (p_drive_after_grant) else $error("drove ungranted");

  property p_read_strobe;
    !read_strobe_n |-> write_strobe_n && !address_latch_n && local_addr_data_oe_n;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("bad read strobe");

  property p_write_strobe;
    !write_strobe_n |-> read_strobe_n && !address_latch_n && !local_addr_data_oe_n;
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("bad write strobe");

  property p_data_strobe;
    !data_strobe_n |-> !address_strobe_n && read_not_write == q.rd && !grant_acknowledge_n_oe_n;
  endproperty
  a_data_strobe: assert property (p_data_strobe) else $error("bad data strobe");

  property p_ack_first;
    !sep && $fell(ctrl_oe_n) |-> !grant_acknowledge_n_oe_n && $past(grant_acknowledge_n_oe_n);
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("acknowledge not taken");

  property p_addr_len;
    $fell(q.state == ST_ADDR) |-> addr_ticks == 4'(q.cfg[`EB_CFG_AEXT_HI:`EB_CFG_AEXT_LO]) + 4'h1;
  endproperty
  a_addr_len: assert property (p_addr_len) else $error("address phase length wrong");

  property p_request_drop;
    $fell(bus_request_hi) |-> read_strobe_n && write_strobe_n ##1 !ctrl_oe_n;
  endproperty
  a_request_drop: assert property (p_request_drop) else $error("request dropped early");

  property p_request_release;
    !sep && $rose(q.state == ST_DATA) |-> bus_request_n;
  endproperty
  a_request_release: assert property (p_request_release) else $error("request held");

endmodule

// ==== bench/expansion_bus_partner.sv ====
`timescale 1ns/1ps
// --------------------
// Arbiter and peripherals
// --------------------
module expansion_bus_partner #(
  parameter logic [31:0] RD_VALUE = 32'h0000_0000
) (
  input  wire logic        aclk,
  input  wire logic        bclk,
  input  wire logic        slow,
  input  wire logic        no_arb,
  input  wire logic        other,
  input  wire logic        req_hi,
  input  wire logic        req_n,
  input  wire logic [31:0] ad_o,
  input  wire logic        ad_oe_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        ds_n,
  input  wire logic        rnw,
  input  wire logic        ack_oe_n,
  output logic             g_hi,
  output logic             g_n,
  output logic             ack_i,
  output logic      [31:0] ad_i,
  output logic      [31:0] wr_cap
);
  logic [2:0]  wait_hi_q = '0, wait_n_q = '0, rd_q = '0;
  logic        gh_q = '0, gn_q = '0;
  logic [31:0] pat_q = '0;
  logic        reading;
  // Grant moves mid-period, clear of the sampled edges
  always @(negedge bclk) begin
    wait_hi_q <= req_hi ? wait_hi_q + 3'h1 : 3'h0;
    wait_n_q  <= req_n ? 3'h0 : wait_n_q + 3'h1;
    gh_q      <= req_hi && (gh_q || wait_hi_q >= {slow, slow});
    gn_q      <= !req_n && (gn_q || wait_n_q >= {slow, slow});
  end
  assign g_hi    = no_arb || gh_q;
  assign g_n     = !(no_arb || gn_q);
  // Open drain with pull-up; another master may hold it
  assign ack_i   = !other && ack_oe_n;
  assign reading = !rd_n || (!ds_n && rnw);
  // Floating lines churn so stale data cannot pass
  assign ad_i    = !ad_oe_n ? ad_o : (reading || |rd_q) ? RD_VALUE : pat_q;
  always @(posedge aclk) begin
    rd_q  <= {rd_q[1:0], reading};
    pat_q <= {pat_q[30:0], ~pat_q[31]};
    if (!wr_n || (!ds_n && !rnw)) begin
      wr_cap <= ad_i;
    end
  end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "expansion_bus_regs.svh"
// --------------------
// Bench
// --------------------
module tb_top;
  localparam logic [31:0] RD_VALUE = 32'h5a3c_96e1;
  logic        aclk = '0, aresetn = '0, bclk = '0, ce = '1;
  logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, ad_i, ad_o, wr_cap;
  logic [3:0]  wstrb = '0, be_n, be_seen;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, ad_oe_n, ctrl_oe_n, ale_n;
  logic        rd_n, wr_n, req_hi, g_hi, as_n, ds_n, rnw, req_n, g_n, ack_i, ack_oe_n;
  logic        slow = '0, no_arb = '0, other = '0, mode = '0, exp_rd = '0;
  logic        granted = '0, ack_prev = '1, oe_prev = '1;
  logic [17:0] exp_addr = '0;
  int          bad_count = 0, total_checks = 0, gap = 0;
  int          n_ale, n_as, n_rd, n_wr, n_ds, n_addr, n_gap;

  always #4 aclk = ~aclk;
  initial begin
    #37.3;
    forever #62.5 bclk = ~bclk;
  end

  expansion_bus_master #(.ADDR_W(8)) u_expansion_bus_master (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .local_bus_clock(bclk), .local_addr_data_i(ad_i), .local_addr_data_o(ad_o),
    .local_addr_data_oe_n(ad_oe_n), .local_byte_enable_n(be_n), .ctrl_oe_n,
    .address_latch_n(ale_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .bus_request_hi(req_hi), .bus_grant_hi(g_hi), .address_strobe_n(as_n),
    .data_strobe_n(ds_n), .read_not_write(rnw), .bus_request_n(req_n), .bus_grant_n(g_n),
    .grant_acknowledge_n_i(ack_i), .grant_acknowledge_n_o(),
    .grant_acknowledge_n_oe_n(ack_oe_n));
  expansion_bus_partner #(.RD_VALUE(RD_VALUE)) u_expansion_bus_partner (
    .aclk, .bclk, .slow, .no_arb, .other, .req_hi, .req_n, .ad_o, .ad_oe_n, .rd_n, .wr_n,
    .ds_n, .rnw, .ack_oe_n, .g_hi, .g_n, .ack_i, .ad_i, .wr_cap);

  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic timed_out;
    chk(1'h0, "timeout");
    finish_test;
  endtask

  // --------------------
  // Watchers
  // --------------------
  // Raw bus edges inside a strobe window equal its length in ticks
  always @(posedge bclk) begin
    n_ale += !ale_n;
    n_as += !as_n;
    n_rd += !rd_n;
    n_wr += !wr_n;
    n_ds += !ds_n;
    n_addr += (!ad_oe_n && ad_o[17:0] === exp_addr);
    n_gap++;
  end
  always @(posedge aclk) begin
    if (aresetn) begin
      if (mode ? (!ale_n || !rd_n || !wr_n || req_hi) : (!as_n || !ds_n || !req_n))
        chk(1'h0, "wrong protocol strobe");
      if ((!ctrl_oe_n || !ad_oe_n) && !granted)
        chk(1'h0, "drove without grant");
      if ((!rd_n || !wr_n) && (!req_hi || (!rd_n && !wr_n)))
        chk(1'h0, "strobe state");
      if (!ds_n && (!req_n || ack_oe_n || rnw !== exp_rd))
        chk(1'h0, "data strobe phase");
      if (!ack_prev && ack_oe_n && ctrl_oe_n)
        chk(1'h0, "lines freed before ack");
      if (ack_prev && !ack_oe_n && other)
        chk(1'h0, "ack taken while held");
    end
    if (mode ? !g_n && !req_n : g_hi && req_hi)
      granted = 1'h1;
    else if (ctrl_oe_n && ad_oe_n && (mode ? req_n : !req_hi))
      granted = 1'h0;
    if (!ctrl_oe_n)
      be_seen = be_n;
    if (ctrl_oe_n && !oe_prev)
      n_gap = 0;
    ack_prev = ack_oe_n;
    oe_prev = ctrl_oe_n;
  end

  // --------------------
  // Register bus
  // --------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'h0;
    if (n == 99) timed_out();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'h0;
    if (n == 99) timed_out();
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic op(input logic [9:0] cfg, input logic rd, input logic [3:0] be,
                    input logic [17:0] a, input logic [31:0] d);
    logic [31:0] v, m;
    logic [1:0]  r;
    logic [3:0]  ln;
    int          n;
    mode = cfg[0];
    exp_rd = rd;
    exp_addr = a;
    ln = cfg[1] ? be & (~be + 4'h1) : be;
    m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    axi_wr(`EB_CFG_OFF, {22'h0, cfg}, r);
    axi_wr(`EB_ADDR_OFF, {14'h0, a}, r);
    axi_wr(`EB_WDATA_OFF, d, r);
    {n_ale, n_as, n_rd, n_wr, n_ds, n_addr} = '0;
    axi_wr(`EB_CTRL_OFF, {24'h0, be, 2'h0, rd, 1'h1}, r);
    if (other) begin
      repeat (40) @(posedge aclk);
      chk(ack_oe_n === 1'h1 && ctrl_oe_n === 1'h1, "took a held bus");
      other <= 1'h0;
    end
    for (n = 0; n < 999; n++) begin
      axi_rd(`EB_STATUS_OFF, v, r);
      if (v[0] === 1'h0) break;
    end
    gap = n_gap;
    if (n == 999) timed_out();
    chk(v[1] === 1'h1, "done flag");
    chk(n_addr === 1 + cfg[3:2], "address hold");
    chk((mode ? n_as : n_ale) === 3 + cfg[3:2] + cfg[6:4], "address strobe");
    chk((mode ? n_ds : rd ? n_rd : n_wr) === 1 + cfg[6:4], "data strobe");
    chk((rd ? n_wr : n_rd) === 0, "idle strobe pulsed");
    chk(gap >= 1 + cfg[9:7] && gap <= 3 + cfg[9:7], "bus gap");
    chk(be_seen === ~ln, "byte enables");
    if (rd) begin
      axi_rd(`EB_RDATA_OFF, v, r);
      chk(v === (RD_VALUE & m), "read data");
    end else
      chk((wr_cap & m) === (d & m), "write data");
  endtask

  task automatic t_regs;
    logic [31:0] v;
    logic [1:0]  r;
    axi_rd(`EB_CFG_OFF, v, r);
    chk(v === `EB_CFG_RESET && r === `EB_RESP_OK, "config reset");
    axi_wr(`EB_CFG_OFF, 32'hffff_ffff, r);
    axi_rd(`EB_CFG_OFF, v, r);
    chk(v === `EB_CFG_MASK, "config write");
    axi_rd(8'h40, v, r);
    chk(r === `EB_RESP_ERR && v === 32'h0, "unmapped read");
    axi_wr(8'h40, 32'h1, r);
    chk(r === `EB_RESP_ERR, "unmapped write");
    $display("test registers done");
  endtask

  task automatic t_separate;
    slow <= 1'h1;
    op(10'h000, 1'h0, 4'hf, 18'h2a5c4, 32'hc3a5_1e0b);
    op(10'h3fc, 1'h1, 4'hf, 18'h15a3b, 32'h0);
    slow <= 1'h0;
    no_arb <= 1'h1;
    op(10'h0a2, 1'h0, 4'h6, 18'h3ffff, 32'h7e81_9a00);
    no_arb <= 1'h0;
    $display("test separate strobes done");
  endtask

  task automatic t_strobe;
    other <= 1'h1;
    op(10'h001, 1'h0, 4'hf, 18'h0c0f3, 32'h9966_3312);
    slow <= 1'h1;
    op(10'h2d7, 1'h1, 4'ha, 18'h2f00d, 32'h0);
    slow <= 1'h0;
    no_arb <= 1'h1;
    op(10'h001, 1'h1, 4'h1, 18'h00001, 32'h0);
    $display("test address strobe done");
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_separate;
    t_strobe;
    finish_test;
  end
endmodule
